//--- rtl/iop_pkg.sv
// iop_pkg: constants, region codes and carrier types for the I/O page
// register bank and its address decoder.
// assumes a 14-bit processor address space reached as one word per byte.
package iop_pkg;

  localparam int unsigned AXI_AW  = 16;
  localparam int unsigned AXI_DW  = 32;
  localparam int unsigned CPU_AW  = 14;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned NPORTS  = 4;
  localparam int unsigned WSTRB_W = AXI_DW / 8;

  // word index = byte address / 4
  localparam int unsigned IDX_LSB = 2;

  // register indices in the I/O page, and the boot ROM range
  localparam logic [CPU_AW-1:0] IDX_PORT_A_PIN_DATA  = 14'h0000;
  localparam logic [CPU_AW-1:0] IDX_PORT_B_PIN_DATA  = 14'h0001;
  localparam logic [CPU_AW-1:0] IDX_PORT_C_PIN_DATA  = 14'h0002;
  localparam logic [CPU_AW-1:0] IDX_PORT_D_PIN_DATA  = 14'h0003;
  localparam logic [CPU_AW-1:0] IDX_PORT_A_DIRECTION = 14'h0004;
  localparam logic [CPU_AW-1:0] IDX_PORT_B_DIRECTION = 14'h0005;
  localparam logic [CPU_AW-1:0] IDX_PORT_C_DIRECTION = 14'h0006;
  localparam logic [CPU_AW-1:0] IDX_PORT_D_DIRECTION = 14'h0007;
  localparam logic [CPU_AW-1:0] IDX_UNUSED_LO        = 14'h0008;
  localparam logic [CPU_AW-1:0] IDX_UNUSED_HI        = 14'h0009;
  localparam logic [CPU_AW-1:0] IDX_PERIPH_LO        = 14'h000a;
  localparam logic [CPU_AW-1:0] IDX_PERIPH_HI        = 14'h001e;
  localparam logic [CPU_AW-1:0] IDX_RESERVED         = 14'h001f;
  localparam logic [CPU_AW-1:0] IDX_PAGE_LAST        = 14'h001f;
  localparam logic [CPU_AW-1:0] IDX_ROM_LO           = 14'h3f00;
  localparam logic [CPU_AW-1:0] IDX_ROM_HI           = 14'h3fef;
  localparam int unsigned       ROM_BYTES            = 239;

  // outside-page control registers; placement is a plain default
  localparam logic [CPU_AW-1:0] IDX_OPTION           = 14'h3ff0;
  localparam logic [CPU_AW-1:0] IDX_MASK_OPT_LO      = 14'h3ff1;
  localparam logic [CPU_AW-1:0] IDX_MASK_OPT_HI      = 14'h3ff2;
  localparam logic [CPU_AW-1:0] IDX_WDOG_ALT_CLEAR   = 14'h3ff3;

  localparam logic [BYTE_W-1:0] DIR_RESET   = 8'h00;
  localparam logic [BYTE_W-1:0] PORT_D_MASK = 8'hbf;
  localparam logic [BYTE_W-1:0] FULL_MASK   = 8'hff;
  localparam logic [BYTE_W-1:0] ZERO_BYTE   = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'b00;

  typedef enum logic [3:0] {
    IOP_RG_PORT_DATA,
    IOP_RG_PORT_DIR,
    IOP_RG_UNUSED,
    IOP_RG_PERIPH,
    IOP_RG_RESERVED,
    IOP_RG_ROM,
    IOP_RG_OPTION,
    IOP_RG_MASK_OPT,
    IOP_RG_WDOG_ALT,
    IOP_RG_MEMORY
  } iop_region_t;

  // access forwarded to the blocks that own the decoded address
  typedef struct packed {
    iop_region_t             region;
    logic [CPU_AW-1:0]       addr;
    logic                    wr;
    logic                    rd;
    logic [BYTE_W-1:0]       wdata;
  } iop_ext_req_t;

  typedef struct packed {
    logic [NPORTS-1:0][BYTE_W-1:0] data;
  } iop_port_bus_t;

endpackage

//--- rtl/iop_decode.sv
// iop_decode: maps a processor address onto the I/O page, the boot
// ROM, the outside-page control registers or plain memory.
// assumes a purely combinational use by the register bank.
`timescale 1ns/1ps
`default_nettype none
module iop_decode
  import iop_pkg::*;
(
  input  wire logic [CPU_AW-1:0] addr,
  output iop_region_t            region,
  output logic [1:0]             port_sel
);

  always_comb begin
    port_sel = addr[1:0];
    if (addr <= IDX_PAGE_LAST) begin
      if (addr <= IDX_PORT_D_PIN_DATA) begin
        region = IOP_RG_PORT_DATA;
      end else if (addr <= IDX_PORT_D_DIRECTION) begin
        region = IOP_RG_PORT_DIR;
      end else if (addr <= IDX_UNUSED_HI) begin
        region = IOP_RG_UNUSED;
      end else if (addr <= IDX_PERIPH_HI) begin
        region = IOP_RG_PERIPH;
      end else begin
        region = IOP_RG_RESERVED;
      end
    end else if (addr >= IDX_ROM_LO && addr <= IDX_ROM_HI) begin
      region = IOP_RG_ROM;
    end else if (addr == IDX_OPTION) begin
      region = IOP_RG_OPTION;
    end else if (addr >= IDX_MASK_OPT_LO && addr <= IDX_MASK_OPT_HI) begin
      region = IOP_RG_MASK_OPT;
    end else if (addr == IDX_WDOG_ALT_CLEAR) begin
      region = IOP_RG_WDOG_ALT;
    end else begin
      region = IOP_RG_MEMORY;
    end
  end

endmodule
`default_nettype wire

//--- rtl/iop_lock.sv
// iop_lock: program memory security lock and the gated external read
// path into program memory.
// assumes the nonvolatile lock cell is reported as a steady level.
`timescale 1ns/1ps
`default_nettype none
module iop_lock
  import iop_pkg::*;
#(
  parameter bit IS_OTP = 1'b0
)(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              nv_locked,
  input  wire logic              lock_set,
  input  wire logic              erase_done,
  input  wire logic              xm_req,
  input  wire logic [CPU_AW-1:0] xm_addr,
  input  wire logic [BYTE_W-1:0] pgm_rdata,
  output logic [CPU_AW-1:0]      pgm_addr,
  output logic [BYTE_W-1:0]      xm_rdata,
  output logic                   xm_ack,
  output logic                   locked
);

  logic locked_q;
  logic loaded_q;
  logic [BYTE_W-1:0] xm_rdata_q;
  logic xm_ack_q;

  // comes out of reset locked so nothing leaks before the cell is read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loaded_q <= 1'b0;
      locked_q <= 1'b1;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      locked_q <= nv_locked | lock_set;
    end else if (lock_set) begin
      locked_q <= 1'b1;
    end else if (erase_done && !IS_OTP) begin
      locked_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xm_rdata_q <= ZERO_BYTE;
      xm_ack_q   <= 1'b0;
    end else begin
      xm_ack_q   <= xm_req;
      xm_rdata_q <= locked_q ? ZERO_BYTE : pgm_rdata;
    end
  end

  // address withheld too, so the memory never sees a locked probe
  assign pgm_addr = (locked_q || !xm_req) ? {CPU_AW{1'b0}} : xm_addr;
  assign xm_rdata = xm_rdata_q;
  assign xm_ack   = xm_ack_q;
  assign locked   = locked_q;

endmodule
`default_nettype wire

//--- rtl/iop_regbank.sv
// iop_regbank: AXI4-Lite slave holding the parallel port data and
// direction registers, forwarding peripheral, ROM, control and memory accesses outward.
// assumes peripherals, ROM and memory answer reads in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module iop_regbank
  import iop_pkg::*;
#(
  parameter bit HAS_PORT_D_DIR = 1'b1,
  parameter bit IS_OTP         = 1'b0
)(
  input  wire logic               CLK_SYS,
  input  wire logic               RSTN,
  input  wire logic [AXI_AW-1:0]  S_AXI_AWADDR,
  input  wire logic [2:0]         S_AXI_AWPROT,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [AXI_DW-1:0]  S_AXI_WDATA,
  input  wire logic [WSTRB_W-1:0] S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic [1:0]              S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [AXI_AW-1:0]  S_AXI_ARADDR,
  input  wire logic [2:0]         S_AXI_ARPROT,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic [AXI_DW-1:0]       S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY,
  input  wire iop_port_bus_t      PORT_PIN_IN,
  output iop_port_bus_t           PORT_PIN_OUT,
  output iop_port_bus_t           PORT_PIN_OE,
  output iop_ext_req_t            EXT_REQ,
  input  wire logic [BYTE_W-1:0]  EXT_RDATA,
  input  wire logic               NV_LOCKED,
  input  wire logic               LOCK_SET,
  input  wire logic               ERASE_DONE,
  input  wire logic               XM_REQ,
  input  wire logic [CPU_AW-1:0]  XM_ADDR,
  input  wire logic [BYTE_W-1:0]  PGM_RDATA,
  output logic [CPU_AW-1:0]       PGM_ADDR,
  output logic [BYTE_W-1:0]       XM_RDATA,
  output logic                    XM_ACK,
  output logic                    LOCKED
);

  // write channel holding registers; address and data may arrive apart
  logic                aw_have_q;
  logic                w_have_q;
  logic [CPU_AW-1:0]   aw_idx_q;
  logic [BYTE_W-1:0]   w_byte_q;
  logic                w_lane_q;
  logic                bvalid_q;
  logic                rvalid_q;
  logic [BYTE_W-1:0]   rdata_q;
  logic                wr_go;
  logic                rd_go;
  logic [CPU_AW-1:0]   ar_idx;
  logic [CPU_AW-1:0]   dec_addr;
  iop_region_t         dec_region;
  logic [1:0]          dec_port;
  logic [BYTE_W-1:0]   rd_byte;

  logic [NPORTS-1:0][BYTE_W-1:0] data_q;
  logic [NPORTS-1:0][BYTE_W-1:0] dir_q;
  logic [NPORTS-1:0][BYTE_W-1:0] pin_view;
  logic [NPORTS-1:0][BYTE_W-1:0] bit_mask;
  logic [NPORTS-1:0]             dir_impl;

  assign ar_idx = S_AXI_ARADDR[IDX_LSB +: CPU_AW];

  assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_have_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = RESP_OKAY;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RRESP   = RESP_OKAY;
  assign S_AXI_RDATA   = {{(AXI_DW-BYTE_W){1'b0}}, rdata_q};

  // a write commits once both halves are held; reads get priority
  // over the shared decoder, so a write waits one cycle behind a read
  assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
  assign wr_go = aw_have_q && w_have_q && !rd_go;

  assign dec_addr = rd_go ? ar_idx : aw_idx_q;

  iop_decode u_decode (
    .addr     (dec_addr),
    .region   (dec_region),
    .port_sel (dec_port)
  );

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= {CPU_AW{1'b0}};
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_q <= 1'b1;
      aw_idx_q  <= S_AXI_AWADDR[IDX_LSB +: CPU_AW];
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  // only byte lane 0 carries register data; other lanes are ignored
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      w_have_q <= 1'b0;
      w_byte_q <= ZERO_BYTE;
      w_lane_q <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_q <= 1'b1;
      w_byte_q <= S_AXI_WDATA[BYTE_W-1:0];
      w_lane_q <= S_AXI_WSTRB[0];
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      bvalid_q <= 1'b0;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rvalid_q <= 1'b0;
      rdata_q  <= ZERO_BYTE;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_byte;
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      localparam bit IS_D = (p == NPORTS - 1);

      assign bit_mask[p] = IS_D ? PORT_D_MASK : FULL_MASK;
      assign dir_impl[p] = IS_D ? HAS_PORT_D_DIR : 1'b1;

      // no reset: the latch keeps what software left there
      always_ff @(posedge CLK_SYS) begin
        if (wr_go && w_lane_q && dec_region == IOP_RG_PORT_DATA &&
            dec_port == 2'(p)) begin
          data_q[p] <= w_byte_q & bit_mask[p];
        end
      end

      always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
          dir_q[p] <= DIR_RESET;
        end else if (wr_go && w_lane_q && dir_impl[p] &&
                     dec_region == IOP_RG_PORT_DIR &&
                     dec_port == 2'(p)) begin
          dir_q[p] <= w_byte_q & bit_mask[p];
        end
      end

      // outputs read back the latch, inputs read the pin
      assign pin_view[p] = ((dir_q[p] & data_q[p]) |
                            (~dir_q[p] & PORT_PIN_IN.data[p])) &
                           bit_mask[p];
      assign PORT_PIN_OUT.data[p] = data_q[p] & bit_mask[p];
      assign PORT_PIN_OE.data[p]  = dir_q[p];
    end
  endgenerate

  // readback mux; holes in the page and absent bits return zero
  always_comb begin
    unique case (dec_region)
      IOP_RG_PORT_DATA: rd_byte = pin_view[dec_port];
      IOP_RG_PORT_DIR:  rd_byte = dir_q[dec_port];
      IOP_RG_UNUSED:    rd_byte = ZERO_BYTE;
      IOP_RG_RESERVED:  rd_byte = ZERO_BYTE;
      IOP_RG_PERIPH:    rd_byte = EXT_RDATA;
      IOP_RG_ROM:       rd_byte = EXT_RDATA;
      IOP_RG_OPTION:    rd_byte = EXT_RDATA;
      IOP_RG_MASK_OPT:  rd_byte = EXT_RDATA;
      IOP_RG_WDOG_ALT:  rd_byte = EXT_RDATA;
      IOP_RG_MEMORY:    rd_byte = EXT_RDATA;
      default:          rd_byte = ZERO_BYTE;
    endcase
  end

  // forwarded strobes; the ROM is never written from the bus
  always_comb begin
    EXT_REQ.region = dec_region;
    EXT_REQ.addr   = dec_addr;
    EXT_REQ.wdata  = w_byte_q;
    EXT_REQ.rd     = rd_go && (dec_region inside {IOP_RG_PERIPH,
                     IOP_RG_ROM, IOP_RG_OPTION, IOP_RG_MASK_OPT,
                     IOP_RG_WDOG_ALT, IOP_RG_MEMORY});
    EXT_REQ.wr     = wr_go && w_lane_q && (dec_region inside {IOP_RG_PERIPH,
                     IOP_RG_OPTION, IOP_RG_MASK_OPT,
                     IOP_RG_WDOG_ALT, IOP_RG_MEMORY});
  end

  iop_lock #(
    .IS_OTP (IS_OTP)
  ) u_lock (
    .clk        (CLK_SYS),
    .rstn       (RSTN),
    .nv_locked  (NV_LOCKED),
    .lock_set   (LOCK_SET),
    .erase_done (ERASE_DONE),
    .xm_req     (XM_REQ),
    .xm_addr    (XM_ADDR),
    .pgm_rdata  (PGM_RDATA),
    .pgm_addr   (PGM_ADDR),
    .xm_rdata   (XM_RDATA),
    .xm_ack     (XM_ACK),
    .locked     (LOCKED)
  );

endmodule
`default_nettype wire

//--- bench/iop_regbank_chk.sv
// iop_regbank_chk: bus, decode and lock assertions for the I/O page.
// assumes a bind onto every iop_regbank, handing down its IS_OTP.
`timescale 1ns/1ps
`default_nettype none
module iop_regbank_chk
  import iop_pkg::*;
#(
  parameter bit IS_OTP = 1'b0
)(
  input wire logic              CLK_SYS,
  input wire logic              RSTN,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic              S_AXI_ARVALID,
  input wire logic              S_AXI_ARREADY,
  input wire logic [AXI_DW-1:0] S_AXI_RDATA,
  input wire logic              S_AXI_RVALID,
  input wire logic              S_AXI_RREADY,
  input wire logic              S_AXI_BVALID,
  input wire logic              S_AXI_BREADY,
  input wire iop_port_bus_t     PORT_PIN_OUT,
  input wire iop_port_bus_t     PORT_PIN_OE,
  input wire iop_ext_req_t      EXT_REQ,
  input wire logic              LOCK_SET,
  input wire logic              ERASE_DONE,
  input wire logic              XM_REQ,
  input wire logic [CPU_AW-1:0] PGM_ADDR,
  input wire logic [BYTE_W-1:0] XM_RDATA,
  input wire logic              XM_ACK,
  input wire logic              LOCKED
);
  logic [1:0]        up_q;
  logic [CPU_AW-1:0] ridx;
  logic              rtake;
  assign ridx = S_AXI_ARADDR[AXI_AW-1:IDX_LSB];
  assign rtake = S_AXI_ARVALID && S_AXI_ARREADY;
  // lock reloads from the cell at the first edge, so skip those edges
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h2) begin
      up_q <= up_q + 2'h1;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  a_rd_answer: assert property (
    rtake |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h0)
    else $error("read answer late or wide");
  a_rd_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_wr_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  a_rom_fwd: assert property (
    rtake && ridx >= IDX_ROM_LO && ridx <= IDX_ROM_HI
      |-> EXT_REQ.rd && EXT_REQ.region == IOP_RG_ROM)
    else $error("boot rom not selected");
  a_periph_fwd: assert property (
    rtake && ridx >= IDX_PERIPH_LO && ridx <= IDX_PERIPH_HI
      |-> EXT_REQ.rd && EXT_REQ.region == IOP_RG_PERIPH)
    else $error("peripheral not selected");
  a_page_local: assert property (
    rtake && (ridx < IDX_PERIPH_LO || ridx == IDX_RESERVED) |-> !EXT_REQ.rd)
    else $error("local address forwarded");
  a_option_out: assert property (
    rtake && ridx == IDX_OPTION |-> EXT_REQ.region == IOP_RG_OPTION)
    else $error("option register misplaced");
  a_xm_locked: assert property (
    XM_REQ && LOCKED |-> PGM_ADDR == '0 ##1 XM_ACK && XM_RDATA == 8'h00)
    else $error("locked memory read leaked");
  a_lock_set: assert property (
    LOCK_SET |=> LOCKED)
    else $error("lock not set");
  a_lock_keep: assert property (
    up_q == 2'h2 && LOCKED && !ERASE_DONE |=> LOCKED)
    else $error("lock released without erase");
  a_erase_clr: assert property (
    up_q == 2'h2 && ERASE_DONE && !LOCK_SET && !IS_OTP |=> !LOCKED)
    else $error("erase left lock set");
  a_otp_keep: assert property (
    up_q == 2'h2 && LOCKED && IS_OTP |=> LOCKED)
    else $error("otp lock released");
  a_fwd_addr: assert property (
    EXT_REQ.rd |-> rtake && EXT_REQ.addr == ridx)
    else $error("forwarded read address wrong");
  a_wr_local: assert property (
    EXT_REQ.wr |-> EXT_REQ.addr >= IDX_PERIPH_LO &&
      EXT_REQ.addr != IDX_RESERVED &&
      !(EXT_REQ.addr >= IDX_ROM_LO && EXT_REQ.addr <= IDX_ROM_HI))
    else $error("local or rom write forwarded");
  a_dir_reset: assert property (
    $rose(RSTN) |-> PORT_PIN_OE == '0)
    else $error("direction not cleared");
  a_pd_bit6: assert property (
    !PORT_PIN_OE.data[3][6] && !PORT_PIN_OUT.data[3][6])
    else $error("port d bit 6 active");
endmodule
bind iop_regbank iop_regbank_chk #(.IS_OTP(IS_OTP)) chk (.*);
`default_nettype wire

//--- bench/iop_regbank_tb.sv
// iop_regbank_tb: register, decode and lock tests over the bus.
// assumes the checker is bound in from its own file.
`timescale 1ns/1ps
`default_nettype none
module iop_regbank_tb
  import iop_pkg::*;
;
  // bench names match the ports so the instance connects by name
  logic CLK_SYS = 1'h0, RSTN = 1'h0;
  logic [AXI_AW-1:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
  logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  logic [AXI_DW-1:0] S_AXI_WDATA = '0, S_AXI_RDATA;
  logic [WSTRB_W-1:0] S_AXI_WSTRB = '0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, XM_ACK, LOCKED, otp_locked;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  iop_port_bus_t PORT_PIN_IN = 32'hff775533, PORT_PIN_OUT, PORT_PIN_OE;
  iop_port_bus_t otp_oe;
  iop_ext_req_t EXT_REQ;
  logic [BYTE_W-1:0] EXT_RDATA = 8'h5a, PGM_RDATA = 8'hc3, XM_RDATA;
  logic NV_LOCKED = 1'h1, LOCK_SET = 1'h0, ERASE_DONE = 1'h0, XM_REQ = 1'h0;
  logic [CPU_AW-1:0] XM_ADDR = '0, PGM_ADDR;
  logic [CPU_AW-1:0] hole[3] = '{14'h8, 14'h9, 14'h1f};
  logic [CPU_AW-1:0] ext[7] = '{14'ha, 14'h1e, 14'h20, 14'h3f00, 14'h3fef,
                                14'h3ff0, 14'h3ff3};
  int num_errors = 0;
  int tests_run = 0;

  iop_regbank dut (.*);
  // second copy on the same bus: otp lock, no port d direction register
  iop_regbank #(.HAS_PORT_D_DIR(1'h0), .IS_OTP(1'h1)) dut_otp (.*,
    .S_AXI_AWREADY(), .S_AXI_WREADY(), .S_AXI_BRESP(), .S_AXI_BVALID(),
    .S_AXI_ARREADY(), .S_AXI_RDATA(), .S_AXI_RRESP(), .S_AXI_RVALID(),
    .PORT_PIN_OUT(), .PORT_PIN_OE(otp_oe), .EXT_REQ(), .PGM_ADDR(),
    .XM_RDATA(), .XM_ACK(), .LOCKED(otp_locked));

  always #2 CLK_SYS = ~CLK_SYS;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d,
                    input logic s = 1'h1);
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= {idx, 2'h0};
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_WSTRB <= {3'h0, s};
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
    end while (!S_AXI_BVALID);
    chk(S_AXI_BRESP, RESP_OKAY);
    S_AXI_BREADY <= 1'h0;
  endtask

  task automatic rc(input logic [13:0] idx, input logic [31:0] e);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= {idx, 2'h0};
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
    end while (!S_AXI_RVALID);
    chk(S_AXI_RDATA, e);
    chk(S_AXI_RRESP, RESP_OKAY);
    S_AXI_RREADY <= 1'h0;
  endtask

  task automatic xm(input logic [13:0] a, input logic [7:0] e,
                    input logic [13:0] pa);
    @(posedge CLK_SYS);
    XM_REQ <= 1'h1;
    XM_ADDR <= a;
    #1 chk(PGM_ADDR, pa);
    @(posedge CLK_SYS);
    XM_REQ <= 1'h0;
    #1 chk({XM_ACK, XM_RDATA}, {1'h1, e});
  endtask

  // the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end

  initial begin
    logic [7:0] v, m;
    repeat (4) @(posedge CLK_SYS);
    RSTN <= 1'h1;
    repeat (2) @(posedge CLK_SYS);
    chk(PORT_PIN_OE, 32'h0);
    chk(LOCKED, 1'h1);
    for (int p = 4; p < 8; p++) rc(14'(p), 32'h0);
    rc(14'h0, 32'h33);
    rc(14'h3, 32'hbf);
    $display("test reset values done");
    for (int p = 0; p < 4; p++) begin
      v = 8'hc5 ^ 8'(p);
      m = (p == 3) ? PORT_D_MASK : FULL_MASK;
      wr(14'(p), v);
      wr(14'(p + 4), 8'hff);
      rc(14'(p), {24'h0, v & m});
      rc(14'(p + 4), {24'h0, m});
      chk(PORT_PIN_OUT.data[p], v & m);
      chk(PORT_PIN_OE.data[p], m);
    end
    chk(otp_oe.data[3], 8'h00);
    chk(otp_oe.data[2], 8'hff);
    wr(14'h4, 8'h00, 1'h0);
    rc(14'h4, 32'hff);
    wr(14'h4, 8'h0f);
    rc(14'h0, 32'h35);
    $display("test port registers done");
    foreach (hole[i]) begin
      wr(hole[i], 8'hff);
      rc(hole[i], 32'h0);
    end
    foreach (ext[i]) rc(ext[i], 32'h5a);
    wr(14'ha, 8'h11);
    wr(14'h3f00, 8'h11);
    $display("test address decode done");
    NV_LOCKED <= 1'h0;
    RSTN <= 1'h0;
    repeat (4) @(posedge CLK_SYS);
    RSTN <= 1'h1;
    repeat (2) @(posedge CLK_SYS);
    chk(PORT_PIN_OE, 32'h0);
    chk(PORT_PIN_OUT.data[1], 8'hc4);
    wr(14'h5, 8'hff);
    rc(14'h1, 32'hc4);
    $display("test reset in mid run done");
    xm(14'h123, 8'hc3, 14'h123);
    @(posedge CLK_SYS);
    LOCK_SET <= 1'h1;
    @(posedge CLK_SYS);
    LOCK_SET <= 1'h0;
    #1 chk({LOCKED, otp_locked}, 2'h3);
    xm(14'h123, 8'h00, 14'h0);
    @(posedge CLK_SYS);
    LOCK_SET <= 1'h1;
    ERASE_DONE <= 1'h1;
    @(posedge CLK_SYS);
    LOCK_SET <= 1'h0;
    ERASE_DONE <= 1'h0;
    #1 chk(LOCKED, 1'h1);
    @(posedge CLK_SYS);
    ERASE_DONE <= 1'h1;
    @(posedge CLK_SYS);
    ERASE_DONE <= 1'h0;
    #1 chk(LOCKED, 1'h0);
    chk(otp_locked, 1'h1);
    xm(14'h2a, 8'hc3, 14'h2a);
    $display("test security lock done");
    stop_test();
  end
endmodule
`default_nettype wire
